// file: include/bwdog_regs.svh
/*
 Register offsets, field positions, reset values and timing figures of the
 board watchdog setup block.
 Assumes inclusion by bare name from the package and the design files.
*/
`ifndef BWDOG_REGS_SVH
`define BWDOG_REGS_SVH

// Address of the setup register on the static memory bus.
`define BWDOG_SETUP_ADDR      32'h13800000
`define BWDOG_SETUP_RESET     8'h03
`define BWDOG_KICK_BIT        3
`define BWDOG_SEL_MSB         2
`define BWDOG_SEL_LSB         0
// Setup codes: code 3 (reset value) disables the watchdog.
`define BWDOG_CODE_1MS        3'h0
`define BWDOG_CODE_10MS       3'h1
`define BWDOG_CODE_30MS       3'h2
`define BWDOG_CODE_OFF        3'h3
`define BWDOG_CODE_100MS      3'h4
`define BWDOG_CODE_1S         3'h5
`define BWDOG_CODE_10S        3'h6
`define BWDOG_CODE_60S        3'h7
// Periods in milliseconds and the clock rate in kHz.
`define BWDOG_T_1MS           1
`define BWDOG_T_10MS          10
`define BWDOG_T_30MS          30
`define BWDOG_T_100MS         100
`define BWDOG_T_1S            1000
`define BWDOG_T_10S           10000
`define BWDOG_T_60S           60000
`define BWDOG_CLK_KHZ         100000
// Length of the board reset pulse in microseconds.
`define BWDOG_T_PULSE_US      1
`define BWDOG_PULSE_CYC       ((`BWDOG_T_PULSE_US * `BWDOG_CLK_KHZ) / 1000)

`endif

// file: include/bwdog_pkg.sv
/*
 Types shared by the board watchdog setup block.
 Assumes bwdog_regs.svh is on the include path.
*/
`include "bwdog_regs.svh"

package bwdog_pkg;

   typedef enum logic [2:0] {
      BWDOG_IDLE  = 3'b001,
      BWDOG_COUNT = 3'b010,
      BWDOG_FIRE  = 3'b100
   } bwdog_state_t;

   typedef logic [2:0] bwdog_sel_t;

endpackage : bwdog_pkg

// file: core/bwdog_period.sv
/*
 Translates a setup code into a timeout length in clock cycles.
 Assumes a 100 MHz clock; the code to length map is purely combinational.
*/
`include "bwdog_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module bwdog_period #(
   parameter int unsigned CLK_KHZ = `BWDOG_CLK_KHZ
) (
   // Setup code in.
   input  wire  logic [2:0]  sel_i,
   // Period out.
   output logic        [32:0] cycles_o,
   output logic               enabled_o
);

   function automatic logic [32:0] ms_to_cyc(input longint unsigned ms);
      ms_to_cyc = 33'(ms * CLK_KHZ);
   endfunction : ms_to_cyc

   always_comb begin
      enabled_o = 1'b1;
      unique case (sel_i)
         `BWDOG_CODE_1MS:   cycles_o = ms_to_cyc(`BWDOG_T_1MS);
         `BWDOG_CODE_10MS:  cycles_o = ms_to_cyc(`BWDOG_T_10MS);
         `BWDOG_CODE_30MS:  cycles_o = ms_to_cyc(`BWDOG_T_30MS);
         `BWDOG_CODE_100MS: cycles_o = ms_to_cyc(`BWDOG_T_100MS);
         `BWDOG_CODE_1S:    cycles_o = ms_to_cyc(`BWDOG_T_1S);
         `BWDOG_CODE_10S:   cycles_o = ms_to_cyc(`BWDOG_T_10S);
         `BWDOG_CODE_60S:   cycles_o = ms_to_cyc(`BWDOG_T_60S);
         `BWDOG_CODE_OFF: begin
            cycles_o  = '0;
            enabled_o = 1'b0;
         end
      endcase
   end

endmodule : bwdog_period
`default_nettype wire

// file: core/bwdog_top.sv
/*
 Board watchdog: an 8-bit setup register on the static memory bus, selected
 by a dedicated chip select, and a timeout supervisor that pulses a board
 reset when the kick bit stays still for a whole period.
 Assumes bus signals are synchronous to core_clk_i and that each access
 holds its strobe for one cycle.
*/
`include "bwdog_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module bwdog_top #(
   parameter int unsigned CLK_KHZ   = `BWDOG_CLK_KHZ,
   parameter int unsigned PULSE_CYC = `BWDOG_PULSE_CYC,
   // Divides every period, for shortened simulation runs.
   parameter int unsigned TIME_DIV  = 1
) (
   // Clock and reset.
   input  wire  logic        core_clk_i,
   input  wire  logic        arst_n_i,
   // Static memory bus.
   input  wire  logic        periph_cs_n_i,
   input  wire  logic        bus_we_i,
   input  wire  logic        bus_re_i,
   input  wire  logic [31:0] bus_addr_i,
   input  wire  logic [7:0]  bus_wdata_i,
   output logic        [7:0] bus_rdata_o,
   // Board reset and status.
   output logic              board_reset_o,
   output logic              wdog_active_o
);

   logic [7:0]             watchdog_setup;
   logic [32:0]            period_cyc;
   logic                   period_en;
   logic [32:0]            count;
   logic [31:0]            pulse_cnt;
   logic                   kick_q;
   logic                   hit;
   logic                   kick_edge;
   logic [32:0]            limit;
   bwdog_pkg::bwdog_state_t state;

   // Chip select selects this register; address is checked in full.
   assign hit = !periph_cs_n_i && (bus_addr_i == `BWDOG_SETUP_ADDR);

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         watchdog_setup <= `BWDOG_SETUP_RESET;
      end else if (hit && bus_we_i) begin
         watchdog_setup <= {4'h0, bus_wdata_i[3:0]};
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         bus_rdata_o <= 8'h00;
      end else if (hit && bus_re_i) begin
         bus_rdata_o <= watchdog_setup;
      end else begin
         bus_rdata_o <= 8'h00;
      end
   end

   bwdog_period #(
      .CLK_KHZ (CLK_KHZ)
   ) u_period (
      .sel_i     (watchdog_setup[`BWDOG_SEL_MSB:`BWDOG_SEL_LSB]),
      .cycles_o  (period_cyc),
      .enabled_o (period_en)
   );

   // Periods shrink by TIME_DIV so that a simulation can reach expiry.
   assign limit = period_cyc / 33'(TIME_DIV);

   // Kick bit of a setup value; the history flop and the edge test share it.
   function automatic logic kick_of(input logic [7:0] setup);
      kick_of = setup[`BWDOG_KICK_BIT];
   endfunction : kick_of

   // The history flop resets to the reset level of the kick bit, so that
   // no false kick is seen on the first cycle after reset.
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         kick_q <= 1'b0;
      end else begin
         kick_q <= kick_of(watchdog_setup);
      end
   end

   // Both rising and falling kick edges restart the count.
   assign kick_edge = kick_q != kick_of(watchdog_setup);

   logic                    expired;
   logic                    pulse_done;
   bwdog_pkg::bwdog_state_t next_state;

   // The count reaches the selected period on this cycle.
   assign expired    = (count + 33'd1) >= limit;
   // This is the last cycle of the board reset pulse.
   assign pulse_done = (pulse_cnt + 32'd1) >= 32'(PULSE_CYC);

   // A kick in the very cycle of expiry wins, so a late kick still saves
   // the board.
   always_comb begin
      next_state = state;
      unique case (state)
         bwdog_pkg::BWDOG_IDLE: begin
            if (period_en) begin
               next_state = bwdog_pkg::BWDOG_COUNT;
            end
         end
         bwdog_pkg::BWDOG_COUNT: begin
            if (!period_en) begin
               next_state = bwdog_pkg::BWDOG_IDLE;
            end else if (!kick_edge && expired) begin
               next_state = bwdog_pkg::BWDOG_FIRE;
            end
         end
         bwdog_pkg::BWDOG_FIRE: begin
            if (pulse_done) begin
               next_state = bwdog_pkg::BWDOG_IDLE;
            end
         end
         default: begin
            next_state = bwdog_pkg::BWDOG_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state <= bwdog_pkg::BWDOG_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // The count only runs while counting; every other state holds it at
   // zero, which also clears it while the reset pulse is out.
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         count <= '0;
      end else if (state != bwdog_pkg::BWDOG_COUNT) begin
         count <= '0;
      end else if (!period_en || kick_edge || expired) begin
         count <= '0;
      end else begin
         count <= count + 33'd1;
      end
   end

   // The pulse length counter sits at zero outside the pulse.
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pulse_cnt <= '0;
      end else if ((state == bwdog_pkg::BWDOG_FIRE) && !pulse_done) begin
         pulse_cnt <= pulse_cnt + 32'd1;
      end else begin
         pulse_cnt <= '0;
      end
   end

   // The board reset is self-timed; software cannot cut it short.
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         board_reset_o <= 1'b0;
      end else begin
         board_reset_o <= (state == bwdog_pkg::BWDOG_FIRE);
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wdog_active_o <= 1'b0;
      end else begin
         wdog_active_o <= period_en;
      end
   end

endmodule : bwdog_top
`default_nettype wire

// file: test/bwdog_host.sv
/* Processor bus model for the setup register.
 Assumes a free-running clock; drives on falling edges. */
`timescale 1ns/1ps
`default_nettype none
module bwdog_host (
   // Bus.
   input  wire logic       clk_i,
   input  wire logic [7:0] rdata_i,
   output logic            cs_n_o, we_o, re_o,
   output logic [31:0]     addr_o,
   output logic [7:0]      wdata_o
);
   initial {cs_n_o, we_o, re_o, addr_o, wdata_o} = {3'b100, 40'h0};
   // Released address and data lines carry the inverse so stale values never match.
   task automatic acc(input logic [31:0] a, input logic c, w,
                      input logic [7:0] d, output logic [7:0] q);
      @(negedge clk_i);
      {cs_n_o, we_o, re_o, addr_o, wdata_o} = {!c, w, !w, a, d};
      @(negedge clk_i);
      q = rdata_i;
      {cs_n_o, we_o, re_o, addr_o, wdata_o} = {3'b100, ~a, ~d};
   endtask : acc
endmodule : bwdog_host
`default_nettype wire

// file: test/bwdog_top_asserts.sv
/* Checker on the bwdog_top ports.
 Assumes one-cycle strobes and reads never paired with writes. */
`timescale 1ns/1ps
`default_nettype none
module bwdog_top_asserts #(
   parameter int unsigned CLK_KHZ = 100000, PULSE_CYC = 100, TIME_DIV = 1
) (
   input wire logic core_clk_i, arst_n_i, periph_cs_n_i, bus_we_i, bus_re_i,
   input wire logic [31:0] bus_addr_i,
   input wire logic [7:0]  bus_wdata_i, bus_rdata_o,
   input wire logic        board_reset_o, wdog_active_o
);
   localparam int unsigned LIM = CLK_KHZ / TIME_DIV;
   logic        hit, chg;
   logic [7:0]  sh;
   logic [31:0] hi_n, q;
   assign hit = !periph_cs_n_i && bus_addr_i == 32'h13800000;
   assign chg = hit && bus_we_i && bus_wdata_i[3:0] != sh[3:0];
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sh <= 8'h03;
         hi_n <= '0;
         q <= '0;
      end else begin
         if (hit && bus_we_i) sh <= {4'h0, bus_wdata_i[3:0]};
         hi_n <= board_reset_o ? hi_n + 1 : '0;
         q <= (chg || board_reset_o) ? '0 : q + 1;
      end
   end
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!arst_n_i);
   rd_data_a: assert property (hit && bus_re_i |=> bus_rdata_o == $past(sh))
      else $error("read data wrong");
   rd_idle_a: assert property (!(hit && bus_re_i) |=> bus_rdata_o == 8'h00)
      else $error("read data not idle");
   active_a: assert property (wdog_active_o == ($past(sh[2:0]) != 3'h3))
      else $error("active flag wrong");
   fire_en_a: assert property ($rose(board_reset_o) |-> $past(sh[2:0]) != 3'h3)
      else $error("reset while disabled");
   fire_act_a: assert property ($rose(board_reset_o) |-> wdog_active_o)
      else $error("reset without active flag");
   pulse_len_a: assert property ($fell(board_reset_o) |-> hi_n == PULSE_CYC)
      else $error("pulse length wrong");
   kick_clr_a: assert property (chg && !board_reset_o |-> ##3 !board_reset_o [*8])
      else $error("reset right after kick");
   fire_time_a: assert property ($rose(board_reset_o) && $past(sh[2:0]) == 3'h0 |-> q >= LIM - 2 && q <= LIM + 6)
      else $error("timeout length wrong");
   cover property ($rose(board_reset_o));
   cover property (hit && bus_re_i);
   cover property ($fell(wdog_active_o));
endmodule : bwdog_top_asserts
bind bwdog_top bwdog_top_asserts #(.CLK_KHZ(CLK_KHZ), .PULSE_CYC(PULSE_CYC),
   .TIME_DIV(TIME_DIV)) u_chk (.*);
`default_nettype wire

// file: test/test_board_watchdog_setup.sv
/* Self-checking bench for bwdog_top.
 Assumes bwdog_host as the processor side. */
`timescale 1ns/1ps
`default_nettype none
module test_board_watchdog_setup;
   localparam logic [31:0] A = 32'h13800000;
   logic        core_clk_i = 1'b0;
   logic        arst_n_i = 1'b0;
   logic        cs_n, we, re, brst, act;
   logic [31:0] ad;
   logic [7:0]  wd, rd, q;
   logic [15:0] rows [3] = '{16'hF505, 16'h0A0A, 16'h0303};
   int fail_count = 0, samples_checked = 0, cyc = 0, rc = 0, n, r0;
   always #5 core_clk_i = ~core_clk_i;
   bwdog_host h (.clk_i(core_clk_i), .rdata_i(rd), .cs_n_o(cs_n), .we_o(we),
      .re_o(re), .addr_o(ad), .wdata_o(wd));
   bwdog_top #(.PULSE_CYC(4), .TIME_DIV(1000)) i_dut (.core_clk_i(core_clk_i),
      .arst_n_i(arst_n_i), .periph_cs_n_i(cs_n), .bus_we_i(we), .bus_re_i(re),
      .bus_addr_i(ad), .bus_wdata_i(wd), .bus_rdata_o(rd),
      .board_reset_o(brst), .wdog_active_o(act));
   task automatic chk(input logic [7:0] s, e);
      samples_checked++;
      if (s !== e) begin
         fail_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk
   task automatic final_report;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : final_report
   always @(posedge core_clk_i) begin
      cyc <= cyc + 1;
      rc <= rc + int'(brst);
      if (cyc == 3000) begin
         fail_count++;
         final_report();
      end
   end
   initial begin
      repeat (2) @(negedge core_clk_i);
      chk({6'h0, brst, act}, 8'h00);
      arst_n_i = 1'b1;
      foreach (rows[i]) begin
         h.acc(A, 1, 0, 0, q);
         chk(q, i ? rows[i-1][7:0] : 8'h03);
         chk({7'h0, act}, {7'h0, i ? rows[i-1][2:0] != 3'h3 : 1'b0});
         h.acc(A, 1, 1, rows[i][15:8], q);
      end
      h.acc(A + 4, 1, 1, 8'h04, q);
      h.acc(A, 0, 1, 8'h04, q);
      h.acc(A, 0, 0, 0, q);
      chk(q, 8'h00);
      h.acc(A, 1, 0, 0, q);
      chk(q, 8'h03);
      $display("end bus");
      h.acc(A, 1, 1, 8'h00, q);
      for (n = 0; !brst && n < 300; n++) @(negedge core_clk_i);
      chk(8'(n >= 98 && n <= 106), 8'h01);
      for (n = 0; brst && n < 20; n++) @(negedge core_clk_i);
      chk(8'(n), 8'h04);
      r0 = rc;
      for (int k = 1; k < 7; k++) begin
         repeat (50) @(negedge core_clk_i);
         h.acc(A, 1, 1, {4'h0, k[0], 3'h0}, q);
      end
      chk(8'(rc - r0), 8'h00);
      h.acc(A, 1, 1, 8'h03, q);
      repeat (300) @(negedge core_clk_i);
      chk(8'(rc - r0), 8'h00);
      $display("end timeout");
      h.acc(A, 1, 1, 8'h06, q);
      arst_n_i = 1'b0;
      @(negedge core_clk_i);
      chk({6'h0, brst, act}, 8'h00);
      arst_n_i = 1'b1;
      h.acc(A, 1, 0, 0, q);
      chk(q, 8'h03);
      $display("end reset");
      final_report();
   end
endmodule : test_board_watchdog_setup
`default_nettype wire
